// ---- src/ertmr_top.sv ----
module ertmr_top (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic event_input_pin_i,
    input wire logic halt_i,
    output logic irq_o
);

    // Reset release synchroniser
    logic rst_sync1_ff;
    logic rst_n;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync1_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_n <= rst_sync1_ff;
        end
    end

    // Register state
    ertmr_pkg::ertmr_mode_e reload_mode_ff;
    logic [2:0] clk_sel_ff;
    logic [7:0] timer_count_value_ff;
    logic [7:0] timer_reload_value_ff;
    logic overflow_request_flag_ff;
    logic overflow_irq_enable_ff;
    logic event_edge_polarity_ff;
    logic [7:0] rdata_ff;

    logic [7:0] nxt_count;
    logic nxt_flag;
    logic [7:0] nxt_rdata;

    // Address decode
    wire sel_mode = addr_i == ertmr_pkg::OFS_MODE;
    wire sel_count = addr_i == ertmr_pkg::OFS_COUNT;
    wire sel_stat = addr_i == ertmr_pkg::OFS_IRQ_STAT;
    wire sel_mask = addr_i == ertmr_pkg::OFS_IRQ_MASK;
    wire sel_edge = addr_i == ertmr_pkg::OFS_EDGE_SEL;

    wire wr_mode = wr_i && sel_mode;
    wire wr_reload = wr_i && sel_count;
    wire wr_mask = wr_i && sel_mask;
    wire wr_edge = wr_i && sel_edge;
    wire rd_stat = rd_i && sel_stat;

    // Event pin synchroniser and edge detector
    logic ev_sync1_ff;
    logic ev_sync2_ff;
    logic ev_prev_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ev_sync1_ff <= 1'b0;
            ev_sync2_ff <= 1'b0;
            ev_prev_ff <= 1'b0;
        end else begin
            ev_sync1_ff <= event_input_pin_i;
            ev_sync2_ff <= ev_sync1_ff;
            ev_prev_ff <= ev_sync2_ff;
        end
    end

    wire ev_rise = ev_sync2_ff && !ev_prev_ff;
    wire ev_fall = !ev_sync2_ff && ev_prev_ff;
    wire ev_edge = event_edge_polarity_ff ? ev_rise : ev_fall;

    // Internal clock taps
    logic presc_tick;

    ertmr_prescaler u_prescaler (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .clk_sel_i(clk_sel_ff),
        .tick_o(presc_tick)
    );

    wire ext_sel = clk_sel_ff == ertmr_pkg::CLK_SEL_EXT;
    wire count_in = ext_sel ? ev_edge : presc_tick;
    wire advance = count_in && !halt_i;
    wire at_max = timer_count_value_ff == ertmr_pkg::COUNT_MAX;
    // A reload write takes precedence over a count input in the same cycle
    wire overflow = advance && at_max && !wr_reload;
    wire [7:0] wrap_value = (reload_mode_ff == ertmr_pkg::ERTMR_AUTO_RELOAD)
                          ? timer_reload_value_ff : ertmr_pkg::COUNT_ZERO;

    assign nxt_count = wr_reload ? wdata_i
                     : overflow ? wrap_value
                     : advance ? timer_count_value_ff + 8'h01
                     : timer_count_value_ff;

    // Set wins over the read-clear
    assign nxt_flag = overflow ? 1'b1 : (rd_stat ? 1'b0 : overflow_request_flag_ff);

    wire [7:0] mode_read = {reload_mode_ff, ertmr_pkg::MODE_RSVD_ONES, clk_sel_ff};
    wire [7:0] stat_read = {7'h00, overflow_request_flag_ff};
    wire [7:0] mask_read = {7'h00, overflow_irq_enable_ff};
    wire [7:0] edge_read = {7'h00, event_edge_polarity_ff};

    assign nxt_rdata = !rd_i ? 8'h00
                     : sel_mode ? mode_read
                     : sel_count ? timer_count_value_ff
                     : sel_stat ? stat_read
                     : sel_mask ? mask_read
                     : sel_edge ? edge_read
                     : 8'h00;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            reload_mode_ff <= ertmr_pkg::ERTMR_INTERVAL;
            clk_sel_ff <= ertmr_pkg::RST_CLK_SEL;
        end else if (wr_mode) begin
            reload_mode_ff <= ertmr_pkg::ertmr_mode_e'(wdata_i[ertmr_pkg::MODE_RELOAD_BIT]);
            clk_sel_ff <= wdata_i[ertmr_pkg::CLK_SEL_LSB +: ertmr_pkg::CLK_SEL_W];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            timer_count_value_ff <= ertmr_pkg::RST_COUNT;
        end else begin
            timer_count_value_ff <= nxt_count;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            timer_reload_value_ff <= ertmr_pkg::RST_RELOAD;
        end else if (wr_reload) begin
            timer_reload_value_ff <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            overflow_request_flag_ff <= ertmr_pkg::RST_FLAG;
        end else begin
            overflow_request_flag_ff <= nxt_flag;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            overflow_irq_enable_ff <= ertmr_pkg::RST_FLAG;
        end else if (wr_mask) begin
            overflow_irq_enable_ff <= wdata_i[ertmr_pkg::IRQ_OVF_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            event_edge_polarity_ff <= ertmr_pkg::RST_FLAG;
        end else if (wr_edge) begin
            event_edge_polarity_ff <= wdata_i[ertmr_pkg::EDGE_POL_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;
    assign irq_o = overflow_request_flag_ff && overflow_irq_enable_ff;

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_reload_write;
        wr_reload;
    endsequence

    sequence s_plain_advance;
        advance && !at_max && !wr_reload;
    endsequence

    sequence s_overflow;
        overflow;
    endsequence

    property p_mode_write;
        wr_mode |=> reload_mode_ff == $past(wdata_i[ertmr_pkg::MODE_RELOAD_BIT]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode bit not written");

    property p_rsvd_read;
        rd_i && sel_mode |=> rdata_o[6:3] == 4'hf && rdata_o[2:0] == clk_sel_ff;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits not one");

    property p_ext_edge;
        ext_sel && ev_edge && !halt_i && !at_max && !wr_reload
            |=> timer_count_value_ff == $past(timer_count_value_ff) + 8'h01;
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("event edge not counted");

    property p_count_up;
        s_plain_advance |=> timer_count_value_ff == $past(timer_count_value_ff) + 8'h01;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not advance");

    property p_flag_set;
        s_overflow |=> overflow_request_flag_ff ##0 (irq_o == overflow_irq_enable_ff);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow flag missing");

    property p_irq_gate;
        !overflow_irq_enable_ff |-> !irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

    property p_wrap;
        s_overflow ##0 (reload_mode_ff == ertmr_pkg::ERTMR_INTERVAL)
            |=> timer_count_value_ff == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("interval wrap wrong");

    property p_load;
        s_reload_write |=> timer_count_value_ff == $past(wdata_i)
            && timer_reload_value_ff == $past(wdata_i);
    endproperty
    a_load: assert property (p_load) else $error("reload write not copied");

    property p_auto_reload;
        s_overflow ##0 (reload_mode_ff == ertmr_pkg::ERTMR_AUTO_RELOAD)
            |=> timer_count_value_ff == timer_reload_value_ff;
    endproperty
    a_auto_reload: assert property (p_auto_reload) else $error("auto reload wrong");

    property p_shared_read;
        rd_i && sel_count |=> rdata_o == $past(timer_count_value_ff);
    endproperty
    a_shared_read: assert property (p_shared_read) else $error("count read wrong");

    property p_halt;
        halt_i && !wr_reload |=> $stable(timer_count_value_ff);
    endproperty
    a_halt: assert property (p_halt) else $error("counter ran while halted");

    property p_one_edge;
        ev_edge |=> !ev_edge;
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("edge counted twice");

endmodule : ertmr_top

// ---- src/ertmr_pkg.sv ----
package ertmr_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PRESC_W = 13;
    localparam int unsigned NUM_TAPS = 7;
    localparam int unsigned CLK_SEL_W = 3;

    // Register map
    localparam logic [15:0] OFS_MODE = 16'hffb2;
    localparam logic [15:0] OFS_COUNT = 16'hffb3;
    localparam logic [15:0] OFS_IRQ_STAT = 16'hffb4;
    localparam logic [15:0] OFS_IRQ_MASK = 16'hffb5;
    localparam logic [15:0] OFS_EDGE_SEL = 16'hffb6;

    // Reset values
    localparam logic [7:0] RST_MODE = 8'h78;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [2:0] RST_CLK_SEL = 3'h0;
    localparam logic RST_FLAG = 1'b0;

    // Field positions
    localparam int unsigned MODE_RELOAD_BIT = 7;
    localparam int unsigned CLK_SEL_LSB = 0;
    localparam logic [3:0] MODE_RSVD_ONES = 4'hf;
    localparam int unsigned IRQ_OVF_BIT = 0;
    localparam int unsigned EDGE_POL_BIT = 0;

    localparam logic [2:0] CLK_SEL_EXT = 3'h7;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_ZERO = 8'h00;

    typedef enum logic {
        ERTMR_INTERVAL = 1'b0,
        ERTMR_AUTO_RELOAD = 1'b1
    } ertmr_mode_e;

    typedef logic [PRESC_W-1:0] ertmr_presc_t;

    // Divide by 8192, 2048, 512, 256, 64, 16, 4
    localparam ertmr_presc_t DIV_MASK [NUM_TAPS] = '{
        13'h1fff, 13'h07ff, 13'h01ff, 13'h00ff, 13'h003f, 13'h000f, 13'h0003
    };

endpackage : ertmr_pkg

// ---- src/ertmr_prescaler.sv ----
module ertmr_prescaler (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [2:0] clk_sel_i,
    output logic tick_o
);

    ertmr_pkg::ertmr_presc_t presc_ff;
    logic [ertmr_pkg::NUM_TAPS-1:0] tap;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            presc_ff <= '0;
        end else begin
            presc_ff <= presc_ff + 13'h0001;
        end
    end

    // One tick per full period of each divided clock
    genvar gi;
    generate
        for (gi = 0; gi < ertmr_pkg::NUM_TAPS; gi++) begin : g_tap
            assign tap[gi] = (presc_ff & ertmr_pkg::DIV_MASK[gi]) == ertmr_pkg::DIV_MASK[gi];
        end
    endgenerate

    assign tick_o = (clk_sel_i == ertmr_pkg::CLK_SEL_EXT) ? 1'b0 : tap[clk_sel_i];

endmodule : ertmr_prescaler

// ---- bench/test_eight_bit_reload_timer.sv ----
module test_eight_bit_reload_timer;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic event_input_pin_i = 1'b0;
    logic halt_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o;
    int err_count = 0;
    int cmp_count = 0;
    logic [7:0] rv;
    logic [7:0] c1;
    int div_tab [7] = '{8192, 2048, 512, 256, 64, 16, 4};

    ertmr_top ertmr_top_i (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .event_input_pin_i(event_input_pin_i),
        .halt_i(halt_i),
        .irq_o(irq_o)
    );

    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    // Leaves the caller at the falling edge of the cycle holding the data
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata_o;
    endtask : rd_reg

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t irq got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        rd_reg(a, rv);
        chk_byte(rv, exp);
    endtask : rd_chk

    // Each level is held long enough to pass the input synchroniser
    task automatic pin_set(input logic v);
        @(posedge clk_sys_i);
        event_input_pin_i <= v;
        repeat (4) @(posedge clk_sys_i);
    endtask : pin_set

    task automatic pulse(input int n);
        repeat (n) begin
            pin_set(1'b1);
            pin_set(1'b0);
        end
    endtask : pulse

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #3_000_000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rd_chk(ertmr_pkg::OFS_MODE, 8'h78);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'h00);
        wr_reg(ertmr_pkg::OFS_MODE, 8'h06);
        rd_chk(ertmr_pkg::OFS_MODE, 8'h7e);
        wr_reg(ertmr_pkg::OFS_MODE, 8'h00);
        wr_reg(ertmr_pkg::OFS_COUNT, 8'h5a);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'h5a);
        wr_reg(16'hffb7, 8'h55);
        rd_chk(16'hffb7, 8'h00);
        rd_chk(16'h0000, 8'h00);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'h5a);
        // Interval mode counting rising edges with the overflow interrupt enabled
        wr_reg(ertmr_pkg::OFS_EDGE_SEL, 8'h01);
        wr_reg(ertmr_pkg::OFS_IRQ_MASK, 8'h01);
        wr_reg(ertmr_pkg::OFS_MODE, 8'h07);
        wr_reg(ertmr_pkg::OFS_COUNT, 8'hfe);
        pulse(1);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'hff);
        chk_bit(irq_o, 1'b0);
        pin_set(1'b1);
        @(negedge clk_sys_i);
        chk_bit(irq_o, 1'b1);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'h00);
        pin_set(1'b0);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'h00);
        rd_chk(ertmr_pkg::OFS_IRQ_STAT, 8'h01);
        chk_bit(irq_o, 1'b0);
        rd_chk(ertmr_pkg::OFS_IRQ_STAT, 8'h00);
        // Masked overflow still sets the flag
        wr_reg(ertmr_pkg::OFS_IRQ_MASK, 8'h00);
        wr_reg(ertmr_pkg::OFS_COUNT, 8'hff);
        pulse(1);
        @(negedge clk_sys_i);
        chk_bit(irq_o, 1'b0);
        rd_chk(ertmr_pkg::OFS_IRQ_STAT, 8'h01);
        // Auto-reload periods of three and of one input
        wr_reg(ertmr_pkg::OFS_MODE, 8'h87);
        rd_chk(ertmr_pkg::OFS_MODE, 8'hff);
        wr_reg(ertmr_pkg::OFS_COUNT, 8'hfd);
        pulse(3);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'hfd);
        rd_chk(ertmr_pkg::OFS_IRQ_STAT, 8'h01);
        wr_reg(ertmr_pkg::OFS_COUNT, 8'hff);
        pulse(1);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'hff);
        rd_chk(ertmr_pkg::OFS_IRQ_STAT, 8'h01);
        // Falling edge polarity
        wr_reg(ertmr_pkg::OFS_EDGE_SEL, 8'h00);
        wr_reg(ertmr_pkg::OFS_MODE, 8'h07);
        wr_reg(ertmr_pkg::OFS_COUNT, 8'h10);
        pin_set(1'b1);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'h10);
        pin_set(1'b0);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'h11);
        // Low-power halt freezes the count and keeps the mode
        @(posedge clk_sys_i);
        halt_i <= 1'b1;
        pulse(2);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'h11);
        rd_chk(ertmr_pkg::OFS_MODE, 8'h7f);
        @(posedge clk_sys_i);
        halt_i <= 1'b0;
        pulse(1);
        rd_chk(ertmr_pkg::OFS_COUNT, 8'h12);
        // Each internal rate gives four ticks over four of its periods
        for (int s = 0; s < 7; s++) begin
            wr_reg(ertmr_pkg::OFS_MODE, 8'(s));
            rd_reg(ertmr_pkg::OFS_COUNT, c1);
            repeat (4 * div_tab[s] - 2) @(posedge clk_sys_i);
            rd_reg(ertmr_pkg::OFS_COUNT, rv);
            chk_byte(rv - c1, 8'h04);
        end
        report_and_stop();
    end

endmodule : test_eight_bit_reload_timer
